// file: src/space_vector_modulation_pkg.sv
// package: timing constants, states and gate and event structs for the single-shunt pwm block
package space_vector_modulation_pkg;
	localparam int        CNT_W          = 16;
	localparam logic [15:0] PERIOD_RST   = 16'h07D0;
	localparam logic [15:0] DEAD_RST     = 16'h0020;
	localparam int        CLK_MHZ        = 40;
	localparam int        BLINK_MS       = 250;
	localparam int        BLINK_CYCLES   = BLINK_MS * CLK_MHZ * 1000;
	localparam logic [15:0] ZERO16       = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RUN   = 3'b010,
		ST_FAULT = 3'b100
	} run_state_t;

	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} gate_t;

	typedef struct packed {
		logic underflow;
		logic overflow;
		logic match;
	} pwm_evt_t;
endpackage

// file: src/single_shunt_space_vector_modulation_adc_sched.sv
// single-shunt three-phase centre-aligned pwm with shunt sample scheduling
//
// How it works
// RULE_01: three up/down modulators give three centre-aligned complementary pairs.
// RULE_02: three high-side and three low-side gate outputs are plain digital pins.
// RULE_03: each conversion start falls halfway through a switching state.
// RULE_04: underflow starts the delay timer and its compare match starts a conversion.
// RULE_05: overflow loads the delay compare with half of first_state_interval.
// RULE_06: conversion done reloads the delay compare with half of second_state_interval.
// RULE_07: buffered duties move to the active compares on overflow and underflow.
// RULE_08: an interrupt pulse is raised on both overflow and underflow.
// RULE_09: the converter is started on overflow and on the delay compare match.
// RULE_10: the overcurrent comparator input disables all modulator outputs.
// RULE_11: the operator switch is one digital input whose presses toggle start and stop.
// RULE_12: high and low outputs of one phase are never on together.
// RULE_13: on a fault the error indicator blinks instead of the motor turning.
// RULE_14: the two samples of a period fall in two different active states; the code samples at overflow (carrier top) and at the delay match.
// RULE_15: each pair inserts programmable dead time before turning a switch on.
// RULE_16: overcurrent shutdown latches until explicitly cleared.
`timescale 1ns/100ps
module single_shunt_space_vector_modulation_adc_sched #(
	parameter int CNT_W        = space_vector_modulation_pkg::CNT_W,
	parameter int BLINK_CYCLES = space_vector_modulation_pkg::BLINK_CYCLES
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	input  wire logic [CNT_W-1:0]    period,
	input  wire logic [CNT_W-1:0]    deadTime,
	input  wire logic [3*CNT_W-1:0]  dutyBuf,
	input  wire logic [CNT_W-1:0]    firstStateInterval,
	input  wire logic [CNT_W-1:0]    secondStateInterval,
	input  wire logic                conversionDone,
	input  wire logic                overcurrentComparator,
	input  wire logic                faultClear,
	input  wire logic                startStopButton,
	input  wire logic                startFail,
	output space_vector_modulation_pkg::gate_t         gate,
	output logic                     pwmIrq,
	output logic                     adcStart,
	output space_vector_modulation_pkg::pwm_evt_t      evt,
	output logic                     errorIndicator,
	output logic                     running
);
	// ----------------------------------------
	// carrier and events
	// ----------------------------------------
	logic [CNT_W-1:0] cnt;
	logic             countDown;
	logic [CNT_W-1:0] dlyCnt;
	logic [CNT_W-1:0] dlyCmp;
	logic             dlyRun;
	logic             btnPrev;
	logic             ocLatch;
	logic [31:0]      blinkCnt;
	space_vector_modulation_pkg::run_state_t state;
	space_vector_modulation_pkg::run_state_t next_state;

	wire atTop      = countDown == 1'b0 && cnt >= period;
	wire atBottom   = countDown == 1'b1 && cnt == space_vector_modulation_pkg::ZERO16[CNT_W-1:0];
	wire overflow   = atTop;
	wire underflow  = atBottom;
	wire dlyMatch   = dlyRun && dlyCnt == dlyCmp;   // [RULE_04]
	wire btnPress   = startStopButton && !btnPrev;  // [RULE_11]
	wire enable     = state == space_vector_modulation_pkg::ST_RUN && !ocLatch; // [RULE_10] [RULE_16]

	// triangle carrier: counts up to period, back to zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt <= '0;
			countDown <= 1'b0;
		end else if (atTop) begin
			countDown <= 1'b1;
			cnt <= cnt - 1'b1;
		end else if (atBottom) begin
			countDown <= 1'b0;
			cnt <= cnt + 1'b1;
		end else begin
			cnt <= countDown ? cnt - 1'b1 : cnt + 1'b1;
		end
	end

	assign evt.overflow  = overflow;
	assign evt.underflow = underflow;
	assign evt.match     = dlyMatch;
	assign pwmIrq        = overflow || underflow;   // [RULE_08]
	assign adcStart      = overflow || dlyMatch;    // [RULE_09] [RULE_14]

	// ----------------------------------------
	// conversion delay timer
	// ----------------------------------------
	// compare change is written at the event so the next start sees the new delay
	always_ff @(posedge mclk) begin
		if (rst) begin
			dlyCnt <= '0;
			dlyCmp <= '0;
			dlyRun <= 1'b0;
		end else begin
			if (underflow) begin
				dlyCnt <= '0;                       // [RULE_04]
				dlyRun <= 1'b1;
			end else if (dlyMatch) begin
				dlyRun <= 1'b0;
			end else if (dlyRun) begin
				dlyCnt <= dlyCnt + 1'b1;
			end
			if (overflow)
				dlyCmp <= firstStateInterval >> 1;  // [RULE_05] [RULE_03]
			else if (conversionDone)
				dlyCmp <= secondStateInterval >> 1; // [RULE_06] [RULE_03]
		end
	end

	// ----------------------------------------
	// run control and fault
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			space_vector_modulation_pkg::ST_IDLE:  if (startFail) next_state = space_vector_modulation_pkg::ST_FAULT;
				else if (btnPress) next_state = space_vector_modulation_pkg::ST_RUN;
			space_vector_modulation_pkg::ST_RUN:   if (ocLatch || startFail) next_state = space_vector_modulation_pkg::ST_FAULT;
				else if (btnPress) next_state = space_vector_modulation_pkg::ST_IDLE;
			space_vector_modulation_pkg::ST_FAULT: if (faultClear && !ocLatch) next_state = space_vector_modulation_pkg::ST_IDLE;
			default:             next_state = space_vector_modulation_pkg::ST_IDLE;
		endcase
	end

	// comparator set wins over a same-cycle clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= space_vector_modulation_pkg::ST_IDLE;
			ocLatch <= 1'b0;
			btnPrev <= 1'b0;
		end else begin
			state <= next_state;
			btnPrev <= startStopButton;
			if (overcurrentComparator)
				ocLatch <= 1'b1;                    // [RULE_10] [RULE_16]
			else if (faultClear)
				ocLatch <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		// follows next_state so the indicator never outlives the fault by a cycle
		if (rst || next_state != space_vector_modulation_pkg::ST_FAULT) begin
			blinkCnt <= '0;
			errorIndicator <= 1'b0;
		end else if (blinkCnt >= 32'(BLINK_CYCLES - 1)) begin
			blinkCnt <= '0;
			errorIndicator <= !errorIndicator;  // [RULE_13]
		end else begin
			blinkCnt <= blinkCnt + 1'b1;
		end
	end

	assign running = state == space_vector_modulation_pkg::ST_RUN;

	// ----------------------------------------
	// three modulators with dead time
	// ----------------------------------------
	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_phase
			logic [CNT_W-1:0] duty;
			logic [CNT_W-1:0] dtCnt;
			logic             rawHigh;
			logic             rawPrev;
			logic             hi;
			logic             lo;
			wire              cmpHigh = cnt < duty;  // [RULE_01]
			always_ff @(posedge mclk) begin
				if (rst) begin
					duty <= '0;
					dtCnt <= '0;
					rawPrev <= 1'b0;
					hi <= 1'b0;
					lo <= 1'b0;
				end else begin
					if (overflow || underflow)
						duty <= dutyBuf[p*CNT_W +: CNT_W]; // [RULE_07]
					rawPrev <= cmpHigh;
					if (!enable) begin
						hi <= 1'b0;                 // [RULE_10]
						lo <= 1'b0;
						dtCnt <= deadTime;
					end else if (cmpHigh != rawPrev) begin
						hi <= 1'b0;                 // [RULE_15]
						lo <= 1'b0;
						dtCnt <= deadTime;
					end else if (dtCnt != '0) begin
						dtCnt <= dtCnt - 1'b1;
					end else begin
						hi <= cmpHigh;              // [RULE_12]
						lo <= !cmpHigh;
					end
				end
			end
			assign gate.high[p] = hi;           // [RULE_02]
			assign gate.low[p]  = lo;

			phase_excl_a: assert property (@(posedge mclk) disable iff (rst) !(hi && lo)) // [RULE_12]
				else $error("high and low on together");
			dead_gap_a: assert property (@(posedge mclk) disable iff (rst)
				$fell(hi) |-> !lo) // [RULE_15]
				else $error("low switched on without dead time");
			duty_load_a: assert property (@(posedge mclk) disable iff (rst)
				(overflow || underflow) |=> duty == $past(dutyBuf[p*CNT_W +: CNT_W])) // [RULE_07]
				else $error("duty not loaded on carrier event");
		end
	endgenerate

	// ----------------------------------------
	// checks
	// ----------------------------------------
	irq_events_a: assert property (@(posedge mclk) disable iff (rst)
		pwmIrq == (overflow || underflow)) // [RULE_08]
		else $error("interrupt not tied to carrier events");
	cmp_first_a: assert property (@(posedge mclk) disable iff (rst)
		overflow |=> dlyCmp == ($past(firstStateInterval) >> 1)) // [RULE_05]
		else $error("delay compare not half first interval");
	cmp_second_a: assert property (@(posedge mclk) disable iff (rst)
		(conversionDone && !overflow) |=> dlyCmp == ($past(secondStateInterval) >> 1)) // [RULE_06]
		else $error("delay compare not half second interval");
	delay_start_a: assert property (@(posedge mclk) disable iff (rst)
		underflow |=> dlyRun && dlyCnt == '0) // [RULE_04]
		else $error("delay timer not started on underflow");
	adc_trig_a: assert property (@(posedge mclk) disable iff (rst)
		(overflow || dlyMatch) |-> adcStart) // [RULE_09]
		else $error("conversion not started");
	oc_kill_a: assert property (@(posedge mclk) disable iff (rst)
		overcurrentComparator |=> ##1 gate == '0) // [RULE_10]
		else $error("outputs not off after overcurrent");
	oc_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(ocLatch && !faultClear) |=> ocLatch) // [RULE_16]
		else $error("overcurrent latch released without clear");
	blink_fault_a: assert property (@(posedge mclk) disable iff (rst)
		errorIndicator |-> state == space_vector_modulation_pkg::ST_FAULT) // [RULE_13]
		else $error("error indicator outside fault");
endmodule

// file: bench/shunt_sense_model.sv
// bench model of the bus-current converter and overcurrent comparator
`timescale 1ns/100ps
module shunt_sense_model (
	input  wire logic mclk,
	input  wire logic adcStart,
	input  wire logic ackEn,
	input  wire logic ocReq,
	output logic      conversionDone,
	output logic      overcurrentComparator
);
	// ----------------
	// converter
	// ----------------
	logic [2:0] pipe = 3'h0;
	// three-clock conversion; ackEn low models a converter that never finishes
	always @(posedge mclk) pipe <= {pipe[1:0], adcStart & ackEn};
	assign conversionDone        = pipe[2];
	assign overcurrentComparator = ocReq;
endmodule

// file: bench/single_shunt_space_vector_modulation_adc_sched_tb.sv
// self-checking bench for the single-shunt pwm block
`timescale 1ns/100ps
module single_shunt_space_vector_modulation_adc_sched_tb;
	localparam logic [15:0] PER = 16'h0014;
	localparam logic [15:0] DT  = 16'h0003;
	typedef struct packed {
		logic [15:0] first;
		logic [15:0] second;
		logic        ack;
		logic [31:0] dly;
	} row_t;
	// expected delay, from the cycle after underflow, is half the interval in force
	row_t rows [4] = '{'{16'h000A, 16'h0006, 1'b0, 32'h5}, '{16'h000A, 16'h0006, 1'b1, 32'h3},
		'{16'h000F, 16'h0008, 1'b0, 32'h7}, '{16'h000F, 16'h0008, 1'b1, 32'h4}};
	logic mclk = 1'b0, rst = 1'b1, faultClear = 1'b0, startStopButton = 1'b0, startFail = 1'b0;
	logic ackEn = 1'b0, ocReq = 1'b0, e0, conversionDone, overcurrentComparator;
	logic pwmIrq, adcStart, errorIndicator, running, lastSide = 1'b0;
	logic [15:0] first = 16'h0000, second = 16'h0000;
	space_vector_modulation_pkg::gate_t    gate;
	space_vector_modulation_pkg::pwm_evt_t evt;
	int fails = 0, n_checks = 0, nOv = 0, nUn = 0, nIrq = 0, nAdc = 0;
	int dlyCnt = 0, lastDly = 0, gapCnt = 0, minGap = 999;
	int s0 = 0, s1 = 0, s2 = 0, s3 = 0;

	single_shunt_space_vector_modulation_adc_sched #(.BLINK_CYCLES(8)) i_dut (.mclk(mclk), .rst(rst),
		.period(PER), .deadTime(DT), .dutyBuf({16'h000F, 16'h000A, 16'h0005}),
		.firstStateInterval(first), .secondStateInterval(second),
		.conversionDone(conversionDone), .overcurrentComparator(overcurrentComparator),
		.faultClear(faultClear), .startStopButton(startStopButton), .startFail(startFail),
		.gate(gate), .pwmIrq(pwmIrq), .adcStart(adcStart), .evt(evt),
		.errorIndicator(errorIndicator), .running(running));
	shunt_sense_model i_model (.mclk(mclk), .adcStart(adcStart), .ackEn(ackEn), .ocReq(ocReq),
		.conversionDone(conversionDone), .overcurrentComparator(overcurrentComparator));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic press();
		startStopButton = 1'b1;
		cyc(1);
		startStopButton = 1'b0;
		cyc(1);
	endtask
	task automatic blink();
		e0 = errorIndicator;
		cyc(8);
		check(32'(errorIndicator ^ e0), 32'h1);
	endtask

	initial forever #12.5 mclk = ~mclk;
	initial begin
		#500000;
		fails++;
		conclude();
	end
	// event counting, match delay and dead gap of phase 0
	always @(posedge mclk) begin
		nOv <= nOv + int'(evt.overflow);
		nUn <= nUn + int'(evt.underflow);
		nIrq <= nIrq + int'(pwmIrq);
		nAdc <= nAdc + int'(adcStart);
		dlyCnt <= evt.underflow ? 0 : dlyCnt + 1;
		if (evt.match)
			lastDly <= dlyCnt;
		if (gate.high[0] | gate.low[0]) begin
			if (gate.high[0] != lastSide && gapCnt < minGap)
				minGap <= gapCnt;
			lastSide <= gate.high[0];
			gapCnt <= 0;
		end else
			gapCnt <= gapCnt + 1;
		if (!rst)
			check(32'(gate.high & gate.low), 32'h0);
	end

	// ----------------
	// stimulus
	// ----------------
	initial begin
		cyc(3);
		check(32'({gate, errorIndicator, running}), 32'h0);
		rst = 1'b0;
		press();
		check(32'(running), 32'h1);
		foreach (rows[i]) begin
			first = rows[i].first;
			second = rows[i].second;
			ackEn = rows[i].ack;
			cyc(4 * int'(PER));
			{s0, s1, s2, s3} = {nOv, nUn, nIrq, nAdc};
			cyc(4 * int'(PER));
			check(nOv - s0, 32'h2);
			check(nUn - s1, 32'h2);
			check(nIrq - s2, 32'h4);
			check(nAdc - s3, 32'h4);
			check(lastDly, rows[i].dly);
		end
		check(32'(minGap >= int'(DT)), 32'h1);
		ocReq = 1'b1;
		cyc(2);
		ocReq = 1'b0;
		cyc(3);
		repeat (12) begin
			check(32'(gate), 32'h0);
			cyc(1);
		end
		blink();
		press();
		// first edge drops the latch, second leaves the fault state
		faultClear = 1'b1;
		cyc(2);
		faultClear = 1'b0;
		cyc(1);
		check(32'({errorIndicator, running}), 32'h0);
		press();
		check(32'(running), 32'h1);
		startFail = 1'b1;
		cyc(1);
		startFail = 1'b0;
		cyc(2);
		check(32'(running), 32'h0);
		blink();
		conclude();
	end
endmodule
